// ===== hw/wsis_pkg.sv
package wsis_pkg;
  // Register offsets on the plain register port
  localparam logic [2:0] ADDR_STEER = 3'h0;
  localparam logic [2:0] ADDR_CLKSEL = 3'h1;
  localparam logic [2:0] ADDR_INSEL = 3'h2;
  localparam logic [2:0] ADDR_CTRL0 = 3'h3;
  localparam logic [2:0] ADDR_CTRL1 = 3'h4;

  // Field positions
  localparam int OVR_LSB = 4;
  localparam int STEER_LSB = 0;
  localparam int CLKSEL_BIT = 0;
  localparam int INSEL_LSB = 0;
  localparam int MODE_LSB = 0;
  localparam int POL_LSB = 0;
  localparam int INVAL_BIT = 5;

  // Values after reset
  localparam logic [7:0] STEER_RST = 8'h00;
  localparam logic CLKSEL_RST = 1'h0;
  localparam logic [3:0] INSEL_RST = 4'h0;
  localparam logic [3:0] POL_RST = 4'h0;

  // Input source codes
  localparam logic [3:0] SRC_LAST = 4'hD;
  localparam int SRC_COUNT = 14;

  // Output modes of the generator
  typedef enum logic [2:0] {
    MODE_STEER = 3'b000,
    MODE_SYNC_STEER = 3'b001,
    MODE_FWD_BRIDGE = 3'b010,
    MODE_REV_BRIDGE = 3'b011,
    MODE_HALF_BRIDGE = 3'b100,
    MODE_PUSH_PULL = 3'b101,
    MODE_RSVD6 = 3'b110,
    MODE_RSVD7 = 3'b111
  } wsis_mode_type;

  localparam wsis_mode_type MODE_RST = MODE_STEER;
endpackage

// ===== hw/wsis_src_mux.sv
`timescale 1ns/10ps
// Picks one internal waveform source; reserved codes yield a steady low
module wsis_src_mux (
  input wire logic [13:0] src_i, // Source channels, index equals code
  input wire logic [3:0] sel_i, // Input source code
  output logic pick_o // Selected level
);
  // Reserved codes connect nothing, so the input rests low and nothing toggles
  always_comb begin
    if (sel_i <= wsis_pkg::SRC_LAST) begin
      pick_o = src_i[sel_i];
    end else begin
      pick_o = 1'b0;
    end
  end
endmodule

// ===== hw/wsis_top.sv
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/10ps
module wsis_top (
  input wire logic CLK_I, // System clock, 125 MHz
  input wire logic NRST_I, // Synchronous reset, active low
  input wire logic CE_I, // Clock enable, freezes all state when low and NRST_I is high
  input wire logic [2:0] ADDR_I, // Register address
  input wire logic [7:0] WDATA_I, // Write data
  input wire logic WR_I, // Write strobe
  input wire logic RD_I, // Read strobe
  output logic [7:0] RDATA_O, // Read data, valid the cycle after RD_I
  input wire logic [13:0] SRC_I, // Internal waveform sources
  input wire logic SHAPED_WAVEFORM_I, // Shaped data waveform from dead-band stage
  input wire logic [3:0] BRIDGE_OUT_I, // Outputs from bridge and push-pull logic
  output logic GEN_INPUT_O, // Selected generator input
  output logic FAST_CLK_SEL_O, // High selects fast internal oscillator
  output logic [2:0] MODE_O, // Output mode for the rest of the unit
  output logic [3:0] OUT_O // Outputs D..A
);
  logic [7:0] steer_r, steer_nxt;
  logic clksel_r, clksel_nxt;
  logic [3:0] insel_r, insel_nxt;
  wsis_pkg::wsis_mode_type mode_r, mode_nxt;
  logic [3:0] pol_r, pol_nxt;
  logic [3:0] act_en_r, act_en_nxt;
  logic shaped_d_r, shaped_d_nxt;
  logic gen_in_r, gen_in_nxt;
  logic [3:0] out_r, out_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic pick;
  logic steering_mode;
  logic [3:0] steer_out;

  // True while steering governs the outputs
  function automatic logic is_steer_mode(input wsis_pkg::wsis_mode_type m);
    is_steer_mode = (m == wsis_pkg::MODE_STEER) || (m == wsis_pkg::MODE_SYNC_STEER);
  endfunction

  wsis_src_mux u_mux (
    .src_i(SRC_I),
    .sel_i(insel_r),
    .pick_o(pick)
  );

  assign steering_mode = is_steer_mode(mode_r);

  // Register writes
  always_comb begin
    steer_nxt = steer_r;
    clksel_nxt = clksel_r;
    insel_nxt = insel_r;
    mode_nxt = mode_r;
    pol_nxt = pol_r;
    if (WR_I) begin
      case (ADDR_I)
        wsis_pkg::ADDR_STEER: steer_nxt = WDATA_I;
        wsis_pkg::ADDR_CLKSEL: clksel_nxt = WDATA_I[wsis_pkg::CLKSEL_BIT];
        wsis_pkg::ADDR_INSEL: insel_nxt = WDATA_I[wsis_pkg::INSEL_LSB +: 4];
        wsis_pkg::ADDR_CTRL0: mode_nxt = wsis_pkg::wsis_mode_type'(WDATA_I[wsis_pkg::MODE_LSB +: 3]);
        wsis_pkg::ADDR_CTRL1: pol_nxt = WDATA_I[wsis_pkg::POL_LSB +: 4];
        default: ;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe; unmapped reads zero
  always_comb begin
    rdata_nxt = 8'h00;
    if (RD_I) begin
      case (ADDR_I)
        wsis_pkg::ADDR_STEER: rdata_nxt = steer_r;
        wsis_pkg::ADDR_CLKSEL: rdata_nxt = {7'h00, clksel_r};
        wsis_pkg::ADDR_INSEL: rdata_nxt = {4'h0, insel_r};
        wsis_pkg::ADDR_CTRL0: rdata_nxt = {5'h00, mode_r};
        wsis_pkg::ADDR_CTRL1: rdata_nxt = {2'h0, gen_in_r, 1'b0, pol_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  // Active steering enables; sync mode waits for a rising waveform edge so
  // a write never chops a pulse in the middle
  always_comb begin
    shaped_d_nxt = SHAPED_WAVEFORM_I;
    act_en_nxt = act_en_r;
    if (mode_r == wsis_pkg::MODE_SYNC_STEER) begin
      if (SHAPED_WAVEFORM_I && !shaped_d_r) begin
        act_en_nxt = steer_r[wsis_pkg::STEER_LSB +: 4];
      end
    end else begin
      act_en_nxt = steer_r[wsis_pkg::STEER_LSB +: 4];
    end
  end

  // Per-output steering: waveform with polarity, or override value
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_out
      assign steer_out[g] = act_en_r[g] ? (SHAPED_WAVEFORM_I ^ pol_r[g])
                                        : steer_r[wsis_pkg::OVR_LSB + g];
    end
  endgenerate

  // Output selection by mode
  always_comb begin
    out_nxt = steering_mode ? steer_out : BRIDGE_OUT_I;
    gen_in_nxt = pick;
  end

  // State registers
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      steer_r <= wsis_pkg::STEER_RST;
      clksel_r <= wsis_pkg::CLKSEL_RST;
      insel_r <= wsis_pkg::INSEL_RST;
      mode_r <= wsis_pkg::MODE_RST;
      pol_r <= wsis_pkg::POL_RST;
      act_en_r <= 4'h0;
      shaped_d_r <= 1'b0;
      gen_in_r <= 1'b0;
      out_r <= 4'h0;
      rdata_r <= 8'h00;
    end else if (CE_I) begin
      steer_r <= steer_nxt;
      clksel_r <= clksel_nxt;
      insel_r <= insel_nxt;
      mode_r <= mode_nxt;
      pol_r <= pol_nxt;
      act_en_r <= act_en_nxt;
      shaped_d_r <= shaped_d_nxt;
      gen_in_r <= gen_in_nxt;
      out_r <= out_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign RDATA_O = rdata_r;
  assign GEN_INPUT_O = gen_in_r;
  assign FAST_CLK_SEL_O = clksel_r;
  assign MODE_O = mode_r;
  assign OUT_O = out_r;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);

  property p_steer_wave;
    (CE_I && steering_mode && act_en_r[0]) |=> (OUT_O[0] == ($past(SHAPED_WAVEFORM_I) ^ $past(pol_r[0])));
  endproperty
  a_steer_wave: assert property (p_steer_wave) else $error("Steered output A wrong");

  property p_override;
    (CE_I && steering_mode && !act_en_r[3]) |=> (OUT_O[3] == $past(steer_r[7]));
  endproperty
  a_override: assert property (p_override) else $error("Override on output D wrong");

  property p_steer_write;
    (CE_I && WR_I && ADDR_I == wsis_pkg::ADDR_STEER) ##1 (CE_I && RD_I && ADDR_I == wsis_pkg::ADDR_STEER)
      |=> (RDATA_O == $past(WDATA_I, 2));
  endproperty
  a_steer_write: assert property (p_steer_write) else $error("Steering readback differs");

  property p_other_mode;
    (CE_I && !steering_mode) |=> (OUT_O == $past(BRIDGE_OUT_I));
  endproperty
  a_other_mode: assert property (p_other_mode) else $error("Steering leaked into bridge mode");

  property p_sync_hold;
    (CE_I && mode_r == wsis_pkg::MODE_SYNC_STEER && !(SHAPED_WAVEFORM_I && !shaped_d_r)) |=> $stable(act_en_r);
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("Sync enables changed without edge");

  property p_clksel;
    (CE_I && WR_I && ADDR_I == wsis_pkg::ADDR_CLKSEL) |=> (FAST_CLK_SEL_O == $past(WDATA_I[0]));
  endproperty
  a_clksel: assert property (p_clksel) else $error("Clock select not taken");

  property p_clk_rsvd;
    $past(CE_I && RD_I && ADDR_I == wsis_pkg::ADDR_CLKSEL) |-> (RDATA_O[7:1] == 7'h00);
  endproperty
  a_clk_rsvd: assert property (p_clk_rsvd) else $error("Clock select upper bits nonzero");

  property p_src_pick;
    (CE_I && insel_r <= wsis_pkg::SRC_LAST) |=> (GEN_INPUT_O == $past(SRC_I[insel_r]));
  endproperty
  a_src_pick: assert property (p_src_pick) else $error("Wrong input source");

  property p_src_rsvd;
    (CE_I && insel_r > wsis_pkg::SRC_LAST) |=> !GEN_INPUT_O;
  endproperty
  a_src_rsvd: assert property (p_src_rsvd) else $error("Reserved source not low");

  property p_is_rsvd;
    $past(CE_I && RD_I && ADDR_I == wsis_pkg::ADDR_INSEL) |-> (RDATA_O[7:4] == 4'h0);
  endproperty
  a_is_rsvd: assert property (p_is_rsvd) else $error("Input select upper bits nonzero");

  // Steered lanes B to D follow the waveform through their own polarity bit
  property p_steer_wave_b;
    (CE_I && steering_mode && act_en_r[1]) |=> (OUT_O[1] == ($past(SHAPED_WAVEFORM_I) ^ $past(pol_r[1])));
  endproperty
  a_steer_wave_b: assert property (p_steer_wave_b) else $error("Steered output B wrong");

  property p_steer_wave_c;
    (CE_I && steering_mode && act_en_r[2]) |=> (OUT_O[2] == ($past(SHAPED_WAVEFORM_I) ^ $past(pol_r[2])));
  endproperty
  a_steer_wave_c: assert property (p_steer_wave_c) else $error("Steered output C wrong");

  property p_steer_wave_d;
    (CE_I && steering_mode && act_en_r[3]) |=> (OUT_O[3] == ($past(SHAPED_WAVEFORM_I) ^ $past(pol_r[3])));
  endproperty
  a_steer_wave_d: assert property (p_steer_wave_d) else $error("Steered output D wrong");

  // Lanes A to C fall back to their override bit when steering is off
  property p_override_a;
    (CE_I && steering_mode && !act_en_r[0]) |=> (OUT_O[0] == $past(steer_r[4]));
  endproperty
  a_override_a: assert property (p_override_a) else $error("Override on output A wrong");

  property p_override_b;
    (CE_I && steering_mode && !act_en_r[1]) |=> (OUT_O[1] == $past(steer_r[5]));
  endproperty
  a_override_b: assert property (p_override_b) else $error("Override on output B wrong");

  property p_override_c;
    (CE_I && steering_mode && !act_en_r[2]) |=> (OUT_O[2] == $past(steer_r[6]));
  endproperty
  a_override_c: assert property (p_override_c) else $error("Override on output C wrong");

  // A clear polarity bit passes the waveform unchanged
  property p_pol_normal;
    (CE_I && steering_mode && act_en_r[1] && !pol_r[1]) |=> (OUT_O[1] == $past(SHAPED_WAVEFORM_I));
  endproperty
  a_pol_normal: assert property (p_pol_normal) else $error("Normal polarity altered output B");

  // A set polarity bit inverts the waveform
  property p_pol_invert;
    (CE_I && steering_mode && act_en_r[2] && pol_r[2]) |=> (OUT_O[2] == !$past(SHAPED_WAVEFORM_I));
  endproperty
  a_pol_invert: assert property (p_pol_invert) else $error("Inverted polarity missing on output C");

  // Enables load on a rising waveform edge in sync mode, every cycle otherwise
  property p_sync_load;
    (CE_I && mode_r == wsis_pkg::MODE_SYNC_STEER && SHAPED_WAVEFORM_I && !shaped_d_r)
      |=> (act_en_r == $past(steer_r[3:0]));
  endproperty
  a_sync_load: assert property (p_sync_load) else $error("Sync enables not loaded on edge");

  property p_direct_load;
    (CE_I && mode_r != wsis_pkg::MODE_SYNC_STEER) |=> (act_en_r == $past(steer_r[3:0]));
  endproperty
  a_direct_load: assert property (p_direct_load) else $error("Enables not applied at once");

  // Mode field written by software reaches the rest of the unit
  property p_mode_out;
    (CE_I && WR_I && ADDR_I == wsis_pkg::ADDR_CTRL0) |=> (MODE_O == $past(WDATA_I[2:0]));
  endproperty
  a_mode_out: assert property (p_mode_out) else $error("Mode field not taken");

  // Input select readback keeps the written code in the low nibble
  property p_insel_write;
    (CE_I && WR_I && ADDR_I == wsis_pkg::ADDR_INSEL) ##1 (CE_I && RD_I && ADDR_I == wsis_pkg::ADDR_INSEL)
      |=> (RDATA_O == {4'h0, $past(WDATA_I[3:0], 2)});
  endproperty
  a_insel_write: assert property (p_insel_write) else $error("Input select readback differs");

  // The input level bit mirrors the registered generator input as it stood at the read
  property p_in_readback;
    $past(CE_I && RD_I && ADDR_I == wsis_pkg::ADDR_CTRL1) |-> (RDATA_O[5] == $past(GEN_INPUT_O));
  endproperty
  a_in_readback: assert property (p_in_readback) else $error("Input level readback differs");

  // Read data rests at zero outside the cycle after a read
  property p_rdata_idle;
    (CE_I && !RD_I) |=> (RDATA_O == 8'h00);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("Read data not idle");

  // Unmapped offsets read as zero
  property p_unmapped;
    $past(CE_I && RD_I && ADDR_I > wsis_pkg::ADDR_CTRL1) |-> (RDATA_O == 8'h00);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("Unmapped read nonzero");

  // A low clock enable holds the steering register, enables, outputs, read data and generator input where they stand
  property p_ce_freeze;
    !CE_I |=> ($stable(steer_r) && $stable(act_en_r) && $stable(OUT_O)
      && $stable(RDATA_O) && $stable(GEN_INPUT_O));
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("State moved while clock enable low");

  // Reset clears all outputs whatever the clock enable does
  property p_reset_outs;
    disable iff (1'b0)
    !NRST_I |=> (OUT_O == 4'h0 && RDATA_O == 8'h00 && MODE_O == 3'h0 && !FAST_CLK_SEL_O && !GEN_INPUT_O);
  endproperty
  a_reset_outs: assert property (p_reset_outs) else $error("Outputs not cleared by reset");

  c_sync_load: cover property (mode_r == wsis_pkg::MODE_SYNC_STEER && CE_I && SHAPED_WAVEFORM_I && !shaped_d_r);
  c_override: cover property (steering_mode && act_en_r != 4'hF && CE_I);
  c_reserved: cover property (insel_r > wsis_pkg::SRC_LAST);
  c_bridge: cover property (CE_I && !steering_mode && OUT_O != 4'h0);
  c_in_read: cover property (CE_I && RD_I && ADDR_I == wsis_pkg::ADDR_CTRL1 && gen_in_r);
endmodule

// ===== verif/wsis_src_model.sv
`timescale 1ns/10ps
// Waveform sources, shaped waveform and bridge stage feeding the block
module wsis_src_model (
  output logic [13:0] src_o, // Source channels
  output logic shaped_o, // Shaped waveform
  output logic [3:0] bridge_o // Bridge stage outputs
);
  initial begin
    src_o = 14'h0000;
    shaped_o = 1'h0;
    bridge_o = 4'h0;
  end
  // Called just after an edge; levels hold until the next call
  task automatic put(input logic [13:0] s, input logic w, input logic [3:0] b);
    src_o <= s;
    shaped_o <= w;
    bridge_o <= b;
  endtask
endmodule

// ===== verif/wsis_top_tb.sv
`timescale 1ns/10ps
// Driver notes expectations in a queue, a monitor compares
module wsis_top_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic look = 1'b0;
  logic look_p = 1'b0;
  logic rd_p = 1'b0;
  logic [7:0] rdata;
  logic [13:0] src;
  logic shaped;
  logic [3:0] bridge;
  logic gen;
  logic fast;
  logic [2:0] mode;
  logic [3:0] outs;
  logic [8:0] exp_q[$];
  logic [8:0] lw;
  logic [7:0] steer = 8'h00;
  logic [3:0] pol = 4'h0;
  logic [3:0] is_r = 4'h0;
  logic [2:0] md = 3'h0;
  logic cs = 1'b0;
  logic [13:0] s = 14'h0000;
  logic w = 1'b0;
  logic [3:0] b = 4'h0;
  int miscompares = 0;
  int n_compared = 0;

  wsis_src_model u_src (.src_o(src), .shaped_o(shaped), .bridge_o(bridge));
  wsis_top uut (.CLK_I(clk), .NRST_I(nrst), .CE_I(ce), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .SRC_I(src), .SHAPED_WAVEFORM_I(shaped), .BRIDGE_OUT_I(bridge), .GEN_INPUT_O(gen),
    .FAST_CLK_SEL_O(fast), .MODE_O(mode), .OUT_O(outs));

  initial forever #4 clk = ~clk;

  task automatic end_sim;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [8:0] g);
    logic [8:0] x;
    x = exp_q.pop_front();
    n_compared++;
    if (g !== x) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, g, x);
    end
  endtask

  // Read data stands one cycle after the strobe; outputs are checked when settled
  always @(posedge clk) begin
    rd_p <= rd;
    look_p <= look;
  end
  always @(negedge clk) begin
    if (rd_p)
      chk({1'b0, rdata});
    if (look_p)
      chk({fast, gen, mode, outs});
  end

  // One bus cycle; every signal is set once per edge, so calls may run back to back
  task automatic cyc(input logic wv, input logic rv, input logic [2:0] a, input logic [7:0] d, input logic l);
    wr <= wv;
    rd <= rv;
    addr <= a;
    wdata <= d;
    look <= l;
    @(posedge clk);
  endtask
  task automatic rreg(input logic [2:0] a, input logic [7:0] x);
    exp_q.push_back({1'b0, x});
    cyc(1'b0, 1'b1, a, 8'h00, 1'b0);
  endtask
  // One idle edge lets a register or input change reach the outputs
  task automatic peek(input logic [8:0] x);
    cyc(1'b0, 1'b0, 3'h0, 8'h00, 1'b0);
    exp_q.push_back(x);
    cyc(1'b0, 1'b0, 3'h0, 8'h00, 1'b1);
  endtask

  function automatic logic [8:0] want();
    logic [3:0] o;
    o = (steer[3:0] & ({4{w}} ^ pol)) | (~steer[3:0] & steer[7:4]);
    return {cs, (is_r < 4'hE) ? s[is_r] : 1'b0, md, (md[2:1] == 2'b00) ? o : b};
  endfunction

  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    $display("unexpected at %0t: run hung", $time);
    end_sim;
  end

  initial begin
    void'($urandom(64));
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 6; i++)
      rreg(3'(i), 8'h00);
    cs = 1'b1;
    is_r = 4'hF;
    cyc(1'b1, 1'b0, wsis_pkg::ADDR_CLKSEL, 8'hFF, 1'b0);
    cyc(1'b1, 1'b0, wsis_pkg::ADDR_INSEL, 8'hFF, 1'b0);
    rreg(wsis_pkg::ADDR_CLKSEL, 8'h01);
    rreg(wsis_pkg::ADDR_INSEL, 8'h0F);
    peek(want());
    // A write while the clock enable is low must be lost
    ce <= 1'b0;
    cyc(1'b1, 1'b0, wsis_pkg::ADDR_CLKSEL, 8'h00, 1'b0);
    ce <= 1'b1;
    rreg(wsis_pkg::ADDR_CLKSEL, 8'h01);
    // Every source code, each chosen channel seen at both levels
    for (int c = 0; c < 16; c++) begin
      is_r = 4'(c);
      s = 14'($urandom);
      cyc(1'b1, 1'b0, wsis_pkg::ADDR_INSEL, {4'h0, is_r}, 1'b0);
      u_src.put(s, w, b);
      peek(want());
      s = ~s;
      u_src.put(s, w, b);
      peek(want());
      lw = want();
      rreg(wsis_pkg::ADDR_CTRL1, {2'h0, lw[7], 5'h00});
    end
    // Steering mode with random enables, overrides and polarity
    for (int k = 0; k < 8; k++) begin
      steer = 8'($urandom);
      pol = 4'($urandom);
      w = k[0];
      cyc(1'b1, 1'b0, wsis_pkg::ADDR_STEER, steer, 1'b0);
      cyc(1'b1, 1'b0, wsis_pkg::ADDR_CTRL1, {4'h0, pol}, 1'b0);
      u_src.put(s, w, b);
      peek(want());
      lw = want();
      rreg(wsis_pkg::ADDR_STEER, steer);
      rreg(wsis_pkg::ADDR_CTRL1, {2'h0, lw[7], 1'b0, pol});
    end
    // Other modes hand the outputs to the bridge stage
    for (int m = 2; m < 8; m++) begin
      md = 3'(m);
      b = 4'($urandom);
      cyc(1'b1, 1'b0, wsis_pkg::ADDR_CTRL0, {5'h00, md}, 1'b0);
      u_src.put(s, w, b);
      peek(want());
      rreg(wsis_pkg::ADDR_CTRL0, {5'h00, md});
    end
    // Enables written in synchronous mode wait for a rising waveform edge
    steer = 8'h00;
    pol = 4'hF;
    md = 3'h1;
    w = 1'b0;
    u_src.put(s, w, b);
    cyc(1'b1, 1'b0, wsis_pkg::ADDR_STEER, 8'h00, 1'b0);
    cyc(1'b1, 1'b0, wsis_pkg::ADDR_CTRL1, 8'h0F, 1'b0);
    cyc(1'b1, 1'b0, wsis_pkg::ADDR_CTRL0, 8'h01, 1'b0);
    cyc(1'b1, 1'b0, wsis_pkg::ADDR_STEER, 8'h0F, 1'b0);
    peek(want());
    peek(want());
    steer = 8'h0F;
    w = 1'b1;
    u_src.put(s, w, b);
    peek(want());
    w = 1'b0;
    u_src.put(s, w, b);
    peek(want());
    // A reset in mid-run returns every register and output to its idle value
    nrst <= 1'b0;
    cyc(1'b0, 1'b0, 3'h0, 8'h00, 1'b0);
    nrst <= 1'b1;
    steer = 8'h00;
    pol = 4'h0;
    is_r = 4'h0;
    md = 3'h0;
    cs = 1'b0;
    peek(want());
    rreg(wsis_pkg::ADDR_STEER, 8'h00);
    rreg(wsis_pkg::ADDR_CTRL0, 8'h00);
    repeat (3) cyc(1'b0, 1'b0, 3'h0, 8'h00, 1'b0);
    if (exp_q.size() != 0) begin
      miscompares++;
      $display("unexpected at %0t: results never seen", $time);
    end
    end_sim;
  end
endmodule
